/* verilog/serial_program_port.v */
// Purpose: serial in-system programming port
// Assumes: memory read data is combinational on memAddr/memEeprom
// Notes:   the memory applies erase, writes and auto-erase itself
//
// How it works
// - input bits sampled on serial clock rise
// - output bits shifted on serial clock fall
// - echo enable key while third byte shifts
// - enable instruction unlocks serial programming
// - chip erase sets both arrays to ff
// - eeprom write erases location by itself
// - extended address byte kept until reloaded
// - load page stores byte half at offset
// - write page commits buffer at page address
// - read eeprom returns addressed byte
// - write eeprom programs fourth byte
// - load eeprom page fills page buffer
// - reads drive data on serial output
// - poll returns busy flag in bit zero

`include "serial_program_port_map.vh"

module serial_program_port #(
  parameter [`WAIT_W-1:0] FLASH_WAIT_CYC  = `FLASH_WAIT_CNT,
  parameter [`WAIT_W-1:0] EEPROM_WAIT_CYC = `EEPROM_WAIT_CNT,
  parameter [`WAIT_W-1:0] ERASE_WAIT_CYC  = `ERASE_WAIT_CNT
) (
  input  wire        clock,
  input  wire        srst,
  input  wire        resetPinN,
  input  wire        serialClock,
  input  wire        serialDataIn,
  input  wire [15:0] memRdData,
  output wire        serialDataOut,
  output reg  [23:0] memAddr,
  output reg  [15:0] memWrData,
  output reg         memWrite,
  output reg         memErase,
  output reg         memEeprom,
  output reg         progActive,
  output reg         progBusy
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam [1:0] RD_FLASH_LO = 2'h0;
  localparam [1:0] RD_FLASH_HI = 2'h1;
  localparam [1:0] RD_EEPROM   = 2'h2;
  localparam [1:0] RD_POLL     = 2'h3;

  wire               sessionOn;
  wire               byteDone;
  wire [1:0]         doneIdx;
  wire [7:0]         rxByte;
  reg  [7:0]         txByte;
  reg  [7:0]         b1_q;
  reg  [7:0]         b2_q;
  reg  [7:0]         b3_q;
  reg  [7:0]         ext_q;
  reg                enabled_q;
  reg                readPend_q;
  reg  [1:0]         readKind_q;
  reg  [15:0]        pageBuf_q [0:63];
  reg  [7:0]         eeBuf_q [0:3];
  reg                seqOn_q;
  reg                seqEe_q;
  reg  [5:0]         seqIdx_q;
  reg  [23:0]        seqBase_q;
  reg  [`WAIT_W-1:0] waitCnt_q;
  wire               busyNow;
  wire               isFlashRd;
  wire               isPageLd;
  wire [5:0]         seqLast;

  // instruction with a byte-half select in bit 3
  function halfOp;
    input [7:0] b;
    input [3:0] hi;
    begin
      halfOp = (b[7:4] == hi) && (b[2:0] == 3'h0);
    end
  endfunction

  assign isFlashRd = halfOp(b1_q, `OP_FLASH_HI4);
  assign isPageLd  = halfOp(b1_q, `OP_PAGE_HI4);
  assign seqLast   = seqEe_q ? 6'h03 : 6'h3f;
  assign busyNow   = seqOn_q || (waitCnt_q != {`WAIT_W{1'b0}});

  // ----------------------------------------------------------------
  // serial framing
  // ----------------------------------------------------------------
  isp_shifter shifter (
    .clock         (clock),
    .srst          (srst),
    .resetPinN     (resetPinN),
    .serialClock   (serialClock),
    .serialDataIn  (serialDataIn),
    .txLoad        (readPend_q),
    .txByte        (txByte),
    .sessionOn     (sessionOn),
    .byteDone      (byteDone),
    .doneIdx       (doneIdx),
    .rxByte        (rxByte),
    .serialDataOut (serialDataOut)
  );

  // ----------------------------------------------------------------
  // answer byte for the fourth slot
  // ----------------------------------------------------------------
  always @* begin
    case (readKind_q)
      RD_FLASH_LO: txByte = memRdData[7:0];
      RD_FLASH_HI: txByte = memRdData[15:8];
      RD_EEPROM:   txByte = memRdData[7:0];
      RD_POLL:     txByte = {7'h00, progBusy};
      default:     txByte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // page buffers
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (enabled_q && byteDone && doneIdx == 2'h3) begin
      if (isPageLd) begin
        if (b1_q[`HALF_SEL_BIT])
          pageBuf_q[b3_q[5:0]][15:8] <= rxByte;
        else
          pageBuf_q[b3_q[5:0]][7:0] <= rxByte;
      end
      if (b1_q == `OP_LOAD_EE_PAGE)
        eeBuf_q[b3_q[7:6]] <= rxByte;
    end
  end

  // ----------------------------------------------------------------
  // instruction execution
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      b1_q       <= 8'h00;
      b2_q       <= 8'h00;
      b3_q       <= 8'h00;
      ext_q      <= 8'h00;
      enabled_q  <= 1'b0;
      readPend_q <= 1'b0;
      readKind_q <= RD_FLASH_LO;
      seqOn_q    <= 1'b0;
      seqEe_q    <= 1'b0;
      seqIdx_q   <= 6'h00;
      seqBase_q  <= 24'h000000;
      waitCnt_q  <= {`WAIT_W{1'b0}};
      memAddr    <= 24'h000000;
      memWrData  <= 16'h0000;
      memWrite   <= 1'b0;
      memErase   <= 1'b0;
      memEeprom  <= 1'b0;
      progActive <= 1'b0;
      progBusy   <= 1'b0;
    end else begin
      memWrite   <= 1'b0;
      memErase   <= 1'b0;
      readPend_q <= 1'b0;
      progBusy   <= busyNow;
      progActive <= sessionOn && enabled_q;
      if (waitCnt_q != {`WAIT_W{1'b0}})
        waitCnt_q <= waitCnt_q - {{(`WAIT_W-1){1'b0}}, 1'b1};
      if (!sessionOn)
        enabled_q <= 1'b0;

      // page commit walks the buffer one word a cycle
      if (seqOn_q) begin
        memWrite  <= 1'b1;
        memEeprom <= seqEe_q;
        if (seqEe_q) begin
          memAddr   <= {seqBase_q[23:2], seqIdx_q[1:0]};
          memWrData <= {8'h00, eeBuf_q[seqIdx_q[1:0]]};
        end else begin
          memAddr   <= {seqBase_q[23:6], seqIdx_q};
          memWrData <= pageBuf_q[seqIdx_q];
        end
        seqIdx_q <= seqIdx_q + 6'h01;
        if (seqIdx_q == seqLast) begin
          seqOn_q   <= 1'b0;
          waitCnt_q <= seqEe_q ? EEPROM_WAIT_CYC
                               : FLASH_WAIT_CYC;
        end
      end

      if (byteDone) begin
        case (doneIdx)
          2'h0: b1_q <= rxByte;
          2'h1: b2_q <= rxByte;
          2'h2: begin
            b3_q <= rxByte;
            // address goes out early so the answer is ready
            // before the next serial clock fall
            if (enabled_q && !seqOn_q) begin
              if (isFlashRd) begin
                memAddr    <= {ext_q, b2_q, rxByte};
                memEeprom  <= 1'b0;
                readPend_q <= 1'b1;
                readKind_q <= b1_q[`HALF_SEL_BIT] ? RD_FLASH_HI
                                                  : RD_FLASH_LO;
              end else if (b1_q == `OP_READ_EE) begin
                memAddr    <= {12'h000, b2_q[3:0], rxByte};
                memEeprom  <= 1'b1;
                readPend_q <= 1'b1;
                readKind_q <= RD_EEPROM;
              end else if (b1_q == `OP_POLL_BUSY) begin
                readPend_q <= 1'b1;
                readKind_q <= RD_POLL;
              end
            end
          end
          default: begin
            if (b1_q == `OP_PROG_ENABLE && b2_q == `OP_ENABLE_KEY)
              enabled_q <= 1'b1;
            if (enabled_q) begin
              if (b1_q == `OP_LOAD_EXT)
                ext_q <= b3_q;
              if (!busyNow) begin
                if (b1_q == `OP_PROG_ENABLE &&
                    b2_q[7:5] == `OP_ERASE_HI3) begin
                  memErase  <= 1'b1;
                  waitCnt_q <= ERASE_WAIT_CYC;
                end
                if (b1_q == `OP_WRITE_PAGE) begin
                  seqOn_q   <= 1'b1;
                  seqEe_q   <= 1'b0;
                  seqIdx_q  <= 6'h00;
                  seqBase_q <= {ext_q, b2_q, b3_q[7:6], 6'h00};
                end
                if (b1_q == `OP_WRITE_EE_PAGE) begin
                  seqOn_q   <= 1'b1;
                  seqEe_q   <= 1'b1;
                  seqIdx_q  <= 6'h00;
                  seqBase_q <= {12'h000, b2_q[3:0], b3_q[7:2], 2'h0};
                end
                if (b1_q == `OP_WRITE_EE) begin
                  memWrite  <= 1'b1;
                  memEeprom <= 1'b1;
                  memAddr   <= {12'h000, b2_q[3:0], b3_q};
                  memWrData <= {8'h00, rxByte};
                  waitCnt_q <= EEPROM_WAIT_CYC;
                end
              end
            end
          end
        endcase
      end
    end
  end

endmodule // serial_program_port

/* verilog/serial_program_port_map.vh */
// Purpose: constants of the serial programming port
// Assumes: 40 MHz block clock
// Notes:   instruction codes are the first byte, except the enable key and erase code, which are the second byte
`ifndef SERIAL_PROGRAM_PORT_MAP_VH
`define SERIAL_PROGRAM_PORT_MAP_VH

// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define OP_PROG_ENABLE   8'hac
`define OP_ENABLE_KEY    8'h53
`define OP_ERASE_HI3     3'h4
`define OP_LOAD_EXT      8'h4d
`define OP_FLASH_HI4     4'h2
`define OP_PAGE_HI4      4'h4
`define OP_WRITE_PAGE    8'h4c
`define OP_READ_EE       8'ha0
`define OP_WRITE_EE      8'hc0
`define OP_LOAD_EE_PAGE  8'hc1
`define OP_WRITE_EE_PAGE 8'hc2
`define OP_POLL_BUSY     8'hf0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define HALF_SEL_BIT     3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WAIT_W           20
// 4.5 ms, 9.0 ms and 9.0 ms counted in 40 MHz block clocks
`define FLASH_WAIT_CNT   20'h2bf20
`define EEPROM_WAIT_CNT  20'h57e40
`define ERASE_WAIT_CNT   20'h57e40

`endif

/* verilog/isp_shifter.v */
// Purpose: serial framing of the programming port
// Assumes: serial clock phases last at least three block clocks
// Notes:   all pins pass two flip-flops before use

module isp_shifter (
  input  wire       clock,
  input  wire       srst,
  input  wire       resetPinN,
  input  wire       serialClock,
  input  wire       serialDataIn,
  input  wire       txLoad,
  input  wire [7:0] txByte,
  output wire       sessionOn,
  output reg        byteDone,
  output reg  [1:0] doneIdx,
  output reg  [7:0] rxByte,
  output reg        serialDataOut
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg  [1:0] sckSync_q;
  reg  [1:0] sdiSync_q;
  reg  [1:0] rstSync_q;
  reg        sckPrev_q;
  reg  [2:0] bitCnt_q;
  reg  [1:0] byteIdx_q;
  reg  [7:0] rx_q;
  reg  [7:0] tx_q;
  wire       rise;
  wire       fall;
  wire [7:0] rxNext;

  always @(posedge clock) begin
    if (srst) begin
      sckSync_q <= 2'h0;
      sdiSync_q <= 2'h0;
      rstSync_q <= 2'h3;
      sckPrev_q <= 1'b0;
    end else begin
      sckSync_q <= {sckSync_q[0], serialClock};
      sdiSync_q <= {sdiSync_q[0], serialDataIn};
      rstSync_q <= {rstSync_q[0], resetPinN};
      sckPrev_q <= sckSync_q[1];
    end
  end

  assign sessionOn = ~rstSync_q[1];
  assign rise      = sckSync_q[1] & ~sckPrev_q;
  assign fall      = ~sckSync_q[1] & sckPrev_q;
  assign rxNext    = {rx_q[6:0], sdiSync_q[1]};

  // ----------------------------------------------------------------
  // shift registers
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (srst || !sessionOn) begin
      bitCnt_q      <= 3'h0;
      byteIdx_q     <= 2'h0;
      rx_q          <= 8'h00;
      tx_q          <= 8'h00;
      byteDone      <= 1'b0;
      doneIdx       <= 2'h0;
      rxByte        <= 8'h00;
      serialDataOut <= 1'b0;
    end else begin
      byteDone <= 1'b0;
      if (rise) begin
        rx_q     <= rxNext;
        bitCnt_q <= bitCnt_q + 3'h1;
        if (bitCnt_q == 3'h7) begin
          // received byte is echoed in the next slot
          byteDone  <= 1'b1;
          doneIdx   <= byteIdx_q;
          rxByte    <= rxNext;
          tx_q      <= rxNext;
          byteIdx_q <= byteIdx_q + 2'h1;
        end
      end else if (fall) begin
        serialDataOut <= tx_q[7];
        tx_q          <= {tx_q[6:0], 1'b0};
      end else if (txLoad) begin
        tx_q <= txByte;
      end
    end
  end

endmodule // isp_shifter

/* verif/serial_program_port_properties.sv */
// Purpose: port checks of the serial programming port
// Assumes: one clock domain, srst synchronous
// Notes:   bound to every serial_program_port
module serial_program_port_properties (
  input logic        clock,
  input logic        srst,
  input logic        resetPinN,
  input logic        serialClock,
  input logic        serialDataIn,
  input logic [15:0] memRdData,
  input logic        serialDataOut,
  input logic [23:0] memAddr,
  input logic [15:0] memWrData,
  input logic        memWrite,
  input logic        memErase,
  input logic        memEeprom,
  input logic        progActive,
  input logic        progBusy
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  one_strobe_a: assert property (!(memWrite && memErase))
    else $error("write and erase strobes together");
  erase_pulse_a: assert property (memErase |-> progActive ##1
    (progBusy && !memErase)) else $error("erase pulse or busy wrong");
  eeprom_busy_a: assert property (memWrite && memEeprom |=>
    progBusy) else $error("no busy after eeprom write");
  page_burst_a: assert property ($rose(memWrite) && !memEeprom |->
    memWrite[*8]) else $error("page walk not back to back");
  busy_refuse_a: assert property (progBusy |-> !memErase)
    else $error("erase taken while busy");
  out_on_fall_a: assert property (disable iff (srst || resetPinN)
    $changed(serialDataOut) |-> !$past(serialClock, 2))
    else $error("serial output moved outside low phase");
  exit_session_a: assert property (resetPinN [*5] |-> !progActive)
    else $error("session still active after reset pin high");
  enable_low_a: assert property ($rose(progActive) ||
    $rose(memWrite) |-> !resetPinN && (progActive || !memWrite))
    else $error("activity outside a session");
endmodule // serial_program_port_properties

bind serial_program_port serial_program_port_properties
  i_serial_program_port_properties (
  .clock(clock), .srst(srst), .resetPinN(resetPinN),
  .serialClock(serialClock), .serialDataIn(serialDataIn),
  .memRdData(memRdData), .serialDataOut(serialDataOut),
  .memAddr(memAddr), .memWrData(memWrData), .memWrite(memWrite),
  .memErase(memErase), .memEeprom(memEeprom),
  .progActive(progActive), .progBusy(progBusy)
);

/* verif/isp_programmer.sv */
// Purpose: far-side programmer driving the serial link
// Assumes: 200 ns link period, phase unrelated to block clock
// Notes:   link clock stands low between frames
module isp_programmer (
  output logic resetPinN,
  output logic serialClock,
  output logic serialDataIn,
  input  logic serialDataOut
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    resetPinN = 1'b0;
    serialClock = 1'b0;
    serialDataIn = 1'b0;
  end

  task automatic session(input logic on);
    resetPinN = ~on;
    #400;
  endtask

  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    #7;
    for (int i = 31; i >= 0; i--) begin
      serialDataIn = w[i];
      #100 serialClock = 1'b1;
      r[i] = serialDataOut;
      #100 serialClock = 1'b0;
    end
    serialDataIn = ~serialDataIn;
  endtask
endmodule // isp_programmer

/* verif/tb_top.sv */
// Purpose: self-checking bench of the serial programming port
// Assumes: shortened wait counts, far-side programmer model
// Notes:   memory behind the port is modelled here
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] memRdData;
  wire         resetPinN, serialClock, serialDataIn, serialDataOut;
  wire  [23:0] memAddr;
  wire  [15:0] memWrData;
  wire         memWrite, memErase, memEeprom, progActive, progBusy;
  int          errors = 0;
  int          comparisons = 0;
  logic [31:0] seed = 32'h59;
  logic [15:0] fl [int];
  logic [7:0]  ee [int];
  logic [15:0] xf [int];
  logic [7:0]  xe [int];
  logic        memTick = 1'b0;

  always #12.5 clock = ~clock;

  serial_program_port #(.FLASH_WAIT_CYC(20'h14),
    .EEPROM_WAIT_CYC(20'h258), .ERASE_WAIT_CYC(20'h258))
    i_serial_program_port (.clock(clock), .srst(srst),
    .resetPinN(resetPinN), .serialClock(serialClock),
    .serialDataIn(serialDataIn), .memRdData(memRdData),
    .serialDataOut(serialDataOut), .memAddr(memAddr),
    .memWrData(memWrData), .memWrite(memWrite), .memErase(memErase),
    .memEeprom(memEeprom), .progActive(progActive),
    .progBusy(progBusy));
  isp_programmer i_isp_programmer (.resetPinN(resetPinN),
    .serialClock(serialClock), .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut));

  // ----------------------------------------------------------------
  // memory behind the port
  // ----------------------------------------------------------------
  // re-evaluated every clock so that a write to an unchanged address shows
  always @(memAddr, memEeprom, memTick) begin
    if (memEeprom)
      memRdData = {8'h00, ee.exists(int'(memAddr[11:0])) ?
        ee[int'(memAddr[11:0])] : 8'hff};
    else
      memRdData = fl.exists(int'(memAddr)) ? fl[int'(memAddr)] : 16'hffff;
  end
  always @(posedge clock) begin
    memTick <= ~memTick;
    if (memErase) begin
      fl.delete();
      ee.delete();
    end
    if (memWrite && memEeprom) ee[int'(memAddr[11:0])] = memWrData[7:0];
    else if (memWrite) fl[int'(memAddr)] = memWrData;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] expFl(input int k, input logic h);
    logic [15:0] v;
    v = xf.exists(k) ? xf[k] : 16'hffff;
    return h ? v[15:8] : v[7:0];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [7:0] a, b, c, d, output logic [31:0] r);
    i_isp_programmer.xfer({a, b, c, d}, r);
  endtask
  task automatic idle(input logic first);
    logic [31:0] q;
    op(8'hf0, 8'h00, 8'h00, 8'h00, q);
    if (first) chk({15'h0, q[0]}, 16'h0001);
    for (int n = 0; n < 40 && q[0] !== 1'b0; n++)
      op(8'hf0, 8'h00, 8'h00, 8'h00, q);
    chk({15'h0, q[0]}, 16'h0000);
  endtask
  task automatic rdEe(input logic [11:0] a);
    logic [31:0] q;
    op(8'ha0, {4'h0, a[11:8]}, a[7:0], 8'h00, q);
    chk({8'h0, q[7:0]}, {8'h0, xe.exists(int'(a)) ? xe[int'(a)] : 8'hff});
  endtask
  task automatic rdFl(input logic [23:0] k, input logic h);
    logic [31:0] q;
    op({4'h2, h, 3'h0}, k[15:8], k[7:0], 8'h00, q);
    chk({8'h0, q[7:0]}, {8'h0, expFl(int'(k), h)});
  endtask
  task automatic finish_test();
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v, q;
    logic [7:0]  ext, b2;
    logic [1:0]  hi;
    logic [11:0] a;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    i_isp_programmer.session(1'b1);
    op(8'hac, 8'h53, 8'h00, 8'h00, q);
    chk({8'h0, q[15:8]}, 16'h0053);
    repeat (4) @(posedge clock);
    chk({15'h0, progActive}, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      v = rnd();
      a = v[11:0];
      op(8'hc0, {4'h0, a[11:8]}, a[7:0], v[19:12], q);
      idle(1'b1);
      op(8'hc0, {4'h0, a[11:8]}, a[7:0], v[27:20], q);
      xe[int'(a)] = v[27:20];
      idle(1'b1);
      rdEe(a);
    end
    v = rnd();
    ext = v[7:0];
    b2 = v[15:8];
    hi = v[17:16];
    op(8'h4d, 8'h00, ext, 8'h00, q);
    for (int w = 0; w < 64; w++) begin
      v = rnd();
      op(8'h40, 8'h00, {v[17:16], 6'(w)}, v[7:0], q);
      op(8'h48, 8'h00, {v[19:18], 6'(w)}, v[15:8], q);
      xf[int'({ext, b2, hi, 6'(w)})] = v[15:0];
    end
    op(8'h4c, b2, {hi, 6'h2a}, 8'h00, q);
    idle(1'b0);
    rdFl({ext, b2, hi, 6'h00}, 1'b0);
    rdFl({ext, b2, hi, 6'h3f}, 1'b1);
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      rdFl({ext, b2, hi, v[5:0]}, v[6]);
    end
    v = rnd();
    a = {v[3:0], v[11:6], 2'b00};
    for (int k = 0; k < 4; k++) begin
      op(8'hc1, 8'h00, {2'(k), 6'h00}, v[19:12] + 8'(k), q);
      xe[int'(a) + k] = v[19:12] + 8'(k);
    end
    op(8'hc2, {4'h0, a[11:8]}, a[7:0], 8'h00, q);
    idle(1'b1);
    for (int k = 0; k < 4; k++) rdEe(a + 12'(k));
    op(8'hac, {3'h4, v[24:20]}, 8'h00, 8'h00, q);
    xe.delete();
    xf.delete();
    idle(1'b1);
    rdEe(a);
    rdFl({ext, b2, hi, 6'h00}, 1'b1);
    i_isp_programmer.session(1'b0);
    repeat (6) @(posedge clock);
    chk({15'h0, progActive}, 16'h0000);
    // new session: commands before the enable are refused
    i_isp_programmer.session(1'b1);
    op(8'ha0, 8'h00, 8'h5a, 8'h00, q);
    chk({8'h0, q[7:0]}, 16'h005a);
    op(8'hc0, {4'h0, a[11:8]}, a[7:0], 8'h12, q);
    op(8'hac, 8'h53, 8'h00, 8'h00, q);
    rdEe(a);
    i_isp_programmer.session(1'b0);
    repeat (6) @(posedge clock);
    chk({15'h0, progActive}, 16'h0000);
    finish_test();
  end

  initial begin
    repeat (90000) @(posedge clock);
    errors++;
    finish_test();
  end
endmodule // tb_top
